/* include/fmps_pkg.sv */
// Constants shared by the flash mode, power and suspend control block.
// Assumes a 20 MHz core clock and a link clock driven by the host.
package fmps_pkg;
    // Core clock period in picoseconds
    localparam int REF_PERIOD_PS = 50000;

    // Opcodes handled here
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    localparam logic [7:0] OP_WRAP_READ = 8'h0c;
    localparam logic [7:0] OP_SET_READ_PARAM = 8'hc0;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
    localparam logic [7:0] OP_RELEASE_ID = 8'hab;
    localparam logic [7:0] OP_QUAD_ENABLE = 8'h38;
    localparam logic [7:0] OP_QUAD_DISABLE = 8'hff;
    // Opcodes refused while suspended, the program ones in program suspend only
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROGRAM = 8'h42;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_QUAD_PROGRAM = 8'h32;

    // Link edge positions (rising edges counted from frame start)
    localparam int LINK_CNT_W = 16;
    localparam logic [15:0] SER_OP_EDGES = 16'h0008;
    localparam logic [15:0] QUAD_OP_EDGES = 16'h0002;
    localparam logic [15:0] SER_ARG_EDGES = 16'h0010;
    localparam logic [15:0] QUAD_ARG_EDGES = 16'h0004;
    localparam logic [15:0] QUAD_ADDR_LAST = 16'h0007;
    localparam logic [15:0] QUAD_ADDR_END = 16'h0008;
    localparam logic [15:0] SER_ID_START = 16'h0020;
    localparam logic [15:0] QUAD_ID_START = 16'h0008;
    localparam logic [15:0] LINK_CNT_MAX = 16'hffff;

    // Dummy clocks per read parameter code, and wrap base length
    localparam logic [15:0] DUMMY_4 = 16'h0004;
    localparam logic [15:0] DUMMY_6 = 16'h0006;
    localparam logic [15:0] DUMMY_8 = 16'h0008;
    localparam logic [6:0] WRAP_BASE = 7'h08;
    localparam logic [7:0] READ_PARAM_RESET = 8'h00;

    // Suspend flag positions
    localparam int SUS_PROG = 0;
    localparam int SUS_ERASE = 1;

    // Timing figures in nanoseconds
    localparam int T_RST_NS = 30000;
    localparam int T_DP_NS = 3000;
    localparam int T_RES1_NS = 8000;
    localparam int T_RES2_NS = 8000;
    localparam int T_SUS_NS = 40000;
    localparam int T_RESUME_NS = 200;

    // Control states, one-hot
    typedef enum logic [3:0] {
        FMPS_IDLE = 4'b0001,
        FMPS_RST_WAIT = 4'b0010,
        FMPS_DP_WAIT = 4'b0100,
        FMPS_REL_WAIT = 4'b1000
    } fmps_state_t;
endpackage

/* hw/fmps_ctrl.sv */
// Mode, power and suspend control of a serial flash command decoder.
// Assumes sclk only toggles while cs_n is low, cs_n high for at least
// four ref_clk periods between frames, and a same-edge array read port.
`timescale 1ns/1ps
`default_nettype none

module fmps_ctrl
    import fmps_pkg::*;
#(
    parameter logic [7:0] DEVICE_ID = 8'h5a, // Arbitrary identifier value
    parameter int RST_NS = T_RST_NS,
    parameter int DP_NS = T_DP_NS,
    parameter int RES1_NS = T_RES1_NS,
    parameter int RES2_NS = T_RES2_NS,
    parameter int SUS_NS = T_SUS_NS
)
(
    // Core clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Serial link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    // Array read port, link clock side
    output logic [23:0] mem_addr,
    input wire logic [7:0] mem_data,
    // Program and erase engine
    input wire logic engine_busy,
    input wire logic engine_program,
    input wire logic engine_erase,
    output logic engine_pause,
    output logic engine_abort,
    // Forwarded commands
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    // Status
    output logic defaults_restore,
    output logic write_in_progress,
    output logic [1:0] suspend_flags,
    output logic quad_command_mode,
    output logic deep_power_down,
    output logic [7:0] read_param_bits,
    output logic busy
);
    // Derived cycle counts, rounded up
    localparam int RST_CYC = (RST_NS * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
    localparam int DP_CYC = (DP_NS * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
    localparam int RES1_CYC = (RES1_NS * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
    localparam int RES2_CYC = (RES2_NS * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
    localparam int SUS_CYC = (SUS_NS * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
    localparam int TMR_W = 16;

    // Link domain signals
    logic link_clr;
    logic [LINK_CNT_W-1:0] cnt;
    logic [LINK_CNT_W-1:0] next_cnt;
    logic [LINK_CNT_W-1:0] last_cnt;
    logic [7:0] sr1;
    logic [7:0] sr4;
    logic [7:0] op1;
    logic [7:0] op4;
    logic [7:0] arg1;
    logic [7:0] arg4;
    logic [23:0] base_addr;
    logic [6:0] ctl_s1;
    logic [6:0] ctl_s2;
    logic [LINK_CNT_W-1:0] data_start;
    logic [LINK_CNT_W-1:0] nib_idx;
    logic [LINK_CNT_W-1:0] next_nib;
    logic [LINK_CNT_W-1:0] id_idx;
    logic [23:0] wrap_mask;
    logic [23:0] next_addr;
    logic wrap_read_on;
    logic ser_id_on;
    logic quad_id_on;

    // Core domain signals
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic cs_level;
    logic frame_end;
    logic q_full;
    logic q_exact8;
    logic q_arg_full;
    logic [7:0] q_op;
    logic [7:0] q_arg;
    logic rst_enabled;
    logic do_reset;
    fmps_state_t state;
    fmps_state_t next_state;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] next_tmr;
    logic [TMR_W-1:0] sus_cnt;

    // Suspend blocking table
    function automatic logic refused_in_suspend(input logic [7:0] op, input logic [1:0] fl);
        logic erase_op;
        erase_op = (op == OP_SECTOR_ERASE) || (op == OP_BLOCK32_ERASE) ||
                   (op == OP_BLOCK64_ERASE) || (op == OP_CHIP_ERASE_A) ||
                   (op == OP_CHIP_ERASE_B);
        refused_in_suspend = 1'b0;
        if (fl[SUS_PROG])
        begin
            refused_in_suspend = erase_op || (op == OP_WRITE_STATUS) ||
                (op == OP_SEC_ERASE) || (op == OP_SEC_PROGRAM) ||
                (op == OP_PAGE_PROGRAM) || (op == OP_QUAD_PROGRAM);
        end
        if (fl[SUS_ERASE])
        begin
            refused_in_suspend = refused_in_suspend || erase_op ||
                (op == OP_WRITE_STATUS) || (op == OP_SEC_ERASE);
        end
    endfunction

    // ---------------- Link clock domain ----------------

    // Frame counter cleared whenever the chip is deselected
    assign link_clr = cs_n | ~rst_n;
    assign next_cnt = (cnt == LINK_CNT_MAX) ? cnt : cnt + 16'h0001;

    always_ff @(posedge sclk or posedge link_clr)
    begin
        if (link_clr)
            cnt <= '0;
        else
            cnt <= next_cnt;
    end

    // Opcode shifting, one bit or one nibble per edge
    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_cnt <= '0;
            sr1 <= 8'h00;
            sr4 <= 8'h00;
            op1 <= 8'h00;
            op4 <= 8'h00;
            arg1 <= 8'h00;
            arg4 <= 8'h00;
        end
        else
        begin
            last_cnt <= next_cnt;
            sr1 <= {sr1[6:0], io_in[0]};
            sr4 <= {sr4[3:0], io_in};
            if (next_cnt == SER_OP_EDGES)
                op1 <= {sr1[6:0], io_in[0]};
            if (next_cnt == QUAD_OP_EDGES)
                op4 <= {sr4[3:0], io_in};
            if (next_cnt == SER_ARG_EDGES)
                arg1 <= {sr1[6:0], io_in[0]};
            if (next_cnt == QUAD_ARG_EDGES)
                arg4 <= {sr4[3:0], io_in};
        end
    end

    // Quasi-static core settings into the link domain
    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_s1 <= 7'h00;
            ctl_s2 <= 7'h00;
        end
        else
        begin
            ctl_s1 <= {quad_command_mode, !deep_power_down && (state == FMPS_IDLE),
                       !write_in_progress && (state != FMPS_RST_WAIT),
                       read_param_bits[5:4], read_param_bits[1:0]};
            ctl_s2 <= ctl_s1;
        end
    end

    // Dummy count and wrap window from the read parameters
    always_comb
    begin
        unique case (ctl_s2[3:2])
            2'b10: data_start = QUAD_ADDR_END + DUMMY_6;
            2'b11: data_start = QUAD_ADDR_END + DUMMY_8;
            default: data_start = QUAD_ADDR_END + DUMMY_4;
        endcase
        wrap_mask = {17'h00000, (WRAP_BASE << ctl_s2[1:0]) - 7'h01};
    end

    // Read modes active in this frame
    assign wrap_read_on = ctl_s2[6] && ctl_s2[5] && (op4 == OP_WRAP_READ);
    assign ser_id_on = !ctl_s2[6] && ctl_s2[4] && (op1 == OP_RELEASE_ID);
    assign quad_id_on = ctl_s2[6] && ctl_s2[4] && (op4 == OP_RELEASE_ID);
    assign nib_idx = cnt - data_start;
    assign next_nib = next_cnt - data_start;
    assign id_idx = ctl_s2[6] ? cnt - QUAD_ID_START : cnt - SER_ID_START;
    assign next_addr = (base_addr & ~wrap_mask) |
                       ((base_addr + {9'h000, next_nib[15:1]}) & wrap_mask);

    // Address capture and wrapped array address
    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_addr <= 24'h000000;
            mem_addr <= 24'h000000;
        end
        else
        begin
            if (cnt >= QUAD_OP_EDGES && cnt <= QUAD_ADDR_LAST)
                base_addr <= {base_addr[19:0], io_in};
            if (wrap_read_on && next_cnt >= data_start)
                mem_addr <= next_addr;
        end
    end

    // Output data launched on falling edges
    always_ff @(negedge sclk or posedge link_clr)
    begin
        if (link_clr)
        begin
            io_out <= 4'h0;
            io_oe <= 4'h0;
        end
        else if (wrap_read_on && cnt >= data_start)
        begin
            io_out <= nib_idx[0] ? mem_data[3:0] : mem_data[7:4];
            io_oe <= 4'hf;
        end
        else if (quad_id_on && cnt >= QUAD_ID_START)
        begin
            io_out <= id_idx[0] ? DEVICE_ID[3:0] : DEVICE_ID[7:4];
            io_oe <= 4'hf;
        end
        else if (ser_id_on && cnt >= SER_ID_START)
        begin
            io_out <= {2'b00, DEVICE_ID[~id_idx[2:0]], 1'b0};
            io_oe <= 4'h2;
        end
        else
        begin
            io_out <= 4'h0;
            io_oe <= 4'h0;
        end
    end

    // ---------------- Core clock domain ----------------

    // Chip select synchroniser with agreement filter
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            cs_level <= 1'b1;
        end
        else
        begin
            cs_s1 <= cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            if (cs_s2 == cs_s3)
                cs_level <= cs_s3;
        end
    end

    // Frame decode from the settled link registers
    assign frame_end = (cs_s2 == cs_s3) && cs_s3 && !cs_level;
    assign q_op = quad_command_mode ? op4 : op1;
    assign q_arg = quad_command_mode ? arg4 : arg1;
    assign q_full = quad_command_mode ? (last_cnt >= QUAD_OP_EDGES)
                                      : (last_cnt >= SER_OP_EDGES);
    assign q_exact8 = quad_command_mode ? (last_cnt == QUAD_OP_EDGES)
                                        : (last_cnt == SER_OP_EDGES);
    assign q_arg_full = quad_command_mode ? (last_cnt >= QUAD_ARG_EDGES)
                                          : (last_cnt >= SER_ARG_EDGES);
    assign do_reset = frame_end && q_full && (state == FMPS_IDLE) &&
                      rst_enabled && (q_op == OP_RESET);

    // Reset enable latch, valid for the next frame only
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_enabled <= 1'b0;
        else if (frame_end && state == FMPS_IDLE)
            rst_enabled <= q_full && (q_op == OP_RESET_ENABLE);
    end

    // Wait state machine and its timer
    always_comb
    begin
        next_state = state;
        next_tmr = (tmr == '0) ? tmr : tmr - 16'h0001;
        unique case (state)
            FMPS_IDLE:
            begin
                if (do_reset)
                begin
                    next_state = FMPS_RST_WAIT;
                    next_tmr = TMR_W'(RST_CYC);
                end
                else if (frame_end && q_full && q_op == OP_POWER_DOWN &&
                         !deep_power_down && q_exact8 && !write_in_progress)
                begin
                    next_state = FMPS_DP_WAIT;
                    next_tmr = TMR_W'(DP_CYC);
                end
                else if (frame_end && q_full && q_op == OP_RELEASE_ID &&
                         deep_power_down && !write_in_progress)
                begin
                    next_state = FMPS_REL_WAIT;
                    next_tmr = q_exact8 ? TMR_W'(RES1_CYC) : TMR_W'(RES2_CYC);
                end
            end
            FMPS_RST_WAIT, FMPS_DP_WAIT, FMPS_REL_WAIT:
            begin
                if (tmr == '0)
                    next_state = FMPS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= FMPS_IDLE;
            tmr <= '0;
        end
        else
        begin
            state <= next_state;
            tmr <= next_tmr;
        end
    end

    // Deep power-down flag
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            deep_power_down <= 1'b0;
        else if (do_reset)
            deep_power_down <= 1'b0;
        else if (state == FMPS_DP_WAIT && tmr == '0)
            deep_power_down <= 1'b1;
        else if (state == FMPS_IDLE && next_state == FMPS_REL_WAIT)
            deep_power_down <= 1'b0;
    end

    // Command mode and read parameters
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            quad_command_mode <= 1'b0;
            read_param_bits <= READ_PARAM_RESET;
        end
        else if (do_reset)
        begin
            quad_command_mode <= 1'b0;
            read_param_bits <= READ_PARAM_RESET;
        end
        else if (frame_end && q_full && state == FMPS_IDLE && !deep_power_down)
        begin
            if (q_op == OP_QUAD_ENABLE)
                quad_command_mode <= 1'b1;
            else if (q_op == OP_QUAD_DISABLE)
                quad_command_mode <= 1'b0;
            if (q_op == OP_SET_READ_PARAM && q_arg_full)
                read_param_bits <= q_arg;
        end
    end

    // Suspend flags and suspend latency counter
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            suspend_flags <= 2'b00;
            sus_cnt <= '0;
        end
        else if (do_reset)
        begin
            suspend_flags <= 2'b00;
            sus_cnt <= '0;
        end
        else
        begin
            if (sus_cnt != '0)
                sus_cnt <= sus_cnt - 16'h0001;
            if (frame_end && q_full && state == FMPS_IDLE && !deep_power_down)
            begin
                if (q_op == OP_SUSPEND && suspend_flags == 2'b00 &&
                    write_in_progress && (engine_program || engine_erase))
                begin
                    suspend_flags[SUS_PROG] <= engine_program;
                    suspend_flags[SUS_ERASE] <= engine_erase && !engine_program;
                    sus_cnt <= TMR_W'(SUS_CYC);
                end
                else if (q_op == OP_RESUME && suspend_flags != 2'b00 &&
                         !write_in_progress)
                begin
                    suspend_flags <= 2'b00;
                    sus_cnt <= '0;
                end
            end
        end
    end

    // Busy flag: drops after suspend latency, back one cycle after resume
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            write_in_progress <= 1'b0;
        else if (do_reset || state == FMPS_RST_WAIT)
            write_in_progress <= 1'b0;
        else
            write_in_progress <= engine_busy &&
                !(suspend_flags != 2'b00 && sus_cnt == '0);
    end

    // Forwarding of all other commands, with refusals
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_valid <= 1'b0;
            cmd_opcode <= 8'h00;
        end
        else
        begin
            cmd_valid <= 1'b0;
            if (frame_end && q_full && state == FMPS_IDLE &&
                !deep_power_down &&
                !refused_in_suspend(q_op, suspend_flags) &&
                q_op != OP_RESET_ENABLE && q_op != OP_RESET &&
                q_op != OP_SUSPEND && q_op != OP_RESUME &&
                q_op != OP_POWER_DOWN && q_op != OP_RELEASE_ID &&
                q_op != OP_QUAD_ENABLE && q_op != OP_QUAD_DISABLE &&
                q_op != OP_SET_READ_PARAM && q_op != OP_WRAP_READ)
            begin
                cmd_valid <= 1'b1;
                cmd_opcode <= q_op;
            end
        end
    end

    // Reset pulses to the engine and volatile status holders
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            engine_abort <= 1'b0;
            defaults_restore <= 1'b0;
        end
        else
        begin
            engine_abort <= do_reset;
            defaults_restore <= do_reset;
        end
    end

    assign engine_pause = suspend_flags != 2'b00;
    assign busy = state != FMPS_IDLE;
endmodule

`default_nettype wire

/* testbench/fmps_props.sv */
// Checker of port relations of the mode, power and suspend control block.
// Bound to fmps_ctrl; sees only its ports, all in the ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
module fmps_props
    import fmps_pkg::*;
#(
    parameter int SUS_NS = T_SUS_NS
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Watched outputs
    input wire logic engine_pause,
    input wire logic engine_abort,
    input wire logic cmd_valid,
    input wire logic defaults_restore,
    input wire logic write_in_progress,
    input wire logic [1:0] suspend_flags,
    input wire logic quad_command_mode,
    input wire logic deep_power_down,
    input wire logic [7:0] read_param_bits,
    input wire logic busy
);
    localparam int SUS_CYC = SUS_NS * 1000 / REF_PERIOD_PS + 4;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_ABORT: assert property (engine_abort |-> defaults_restore && busy
        && suspend_flags == 2'b00 && !deep_power_down && read_param_bits == 8'h00)
        else $error("reset left state behind");
    AST_REFUSE: assert property (cmd_valid |-> !$past(busy))
        else $error("command taken while busy");
    AST_SUS_OK: assert property ($rose(|suspend_flags) |-> $past(write_in_progress))
        else $error("suspend taken while idle");
    AST_SUS_WIP: assert property ($rose(|suspend_flags) |-> ##[1:SUS_CYC] !write_in_progress)
        else $error("busy flag kept after suspend");
    AST_PAUSE: assert property ($rose(|suspend_flags) |-> ##[0:1] engine_pause)
        else $error("engine not paused");
    AST_RESUME: assert property ($fell(|suspend_flags) && !defaults_restore
        |-> ##[0:4] write_in_progress)
        else $error("busy flag late after resume");
    AST_DP_ENTRY: assert property ($rose(deep_power_down) |-> $past(busy) && !write_in_progress)
        else $error("power-down entered wrongly");
    AST_DP_HOLD: assert property (deep_power_down && $past(deep_power_down)
        |-> $stable(quad_command_mode) && $stable(read_param_bits))
        else $error("command acted in power-down");
    AST_MODE: assert property (quad_command_mode != $past(quad_command_mode) && !defaults_restore
        |-> $stable(suspend_flags) && $stable(read_param_bits))
        else $error("mode switch changed state");
    // Main scenarios reached
    cover property ($rose(|suspend_flags));
    cover property ($rose(deep_power_down));
    cover property (engine_abort);
endmodule
bind fmps_ctrl fmps_props #(.SUS_NS(SUS_NS)) fmps_props_inst (.ref_clk, .rst_n,
    .engine_pause, .engine_abort, .cmd_valid, .defaults_restore, .write_in_progress,
    .suspend_flags, .quad_command_mode, .deep_power_down, .read_param_bits, .busy);
`default_nettype wire

/* testbench/fmps_host.sv */
// Host model: sends link frames, captures reply bytes, serves the array.
// Link clock is 160 ns and stands still low between frames.
`timescale 1ns/1ps
`default_nettype none
module fmps_host
(
    // Link pins
    output logic sclk,
    output logic cs_n,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe,
    // Array read port
    input wire logic [23:0] mem_addr,
    output logic [7:0] mem_data
);
    logic [3:0] drv = 4'h0;
    logic [7:0] rx [$];
    // Wire level from both drivers
    assign io_in = (io_oe & io_out) | (~io_oe & drv);
    // Array byte follows its address
    assign mem_data = mem_addr[7:0] ^ 8'ha5;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    // One frame: opcode, then nb argument bytes
    task automatic xfer(input logic [7:0] op, input logic [7:0] arg, input int nb, input bit q);
        logic [7:0] b;
        logic [7:0] r;
        rx.delete();
        cs_n = 1'b0;
        for (int n = 0; n <= nb; n++)
        begin
            b = (n == 0) ? op : arg;
            for (int i = 0; i < (q ? 2 : 8); i++)
            begin
                drv = q ? (i == 0 ? b[7:4] : b[3:0]) : {3'b000, b[7 - i]};
                #80 sclk = 1'b1;
                r = q ? {r[3:0], io_in} : {r[6:0], io_in[1]};
                #80 sclk = 1'b0;
            end
            rx.push_back(r);
        end
        #80 cs_n = 1'b1;
        drv = ~drv;
    endtask
endmodule
`default_nettype wire

/* testbench/fmps_ctrl_tb.sv */
// Bench of the control block: host model frames, bench-driven engine.
// Shortened timing parameters; expectations from bench functions.
`timescale 1ns/1ps
`default_nettype none
module fmps_ctrl_tb
    import fmps_pkg::*;
;
    localparam logic [7:0] ID = 8'h3c; // Arbitrary identifier value
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, cs_n, engine_pause, engine_abort, cmd_valid, defaults_restore, busy;
    logic write_in_progress, quad_command_mode, deep_power_down;
    logic [3:0] io_in, io_out, io_oe;
    logic [23:0] mem_addr;
    logic [7:0] mem_data, cmd_opcode, read_param_bits, p, a;
    logic [1:0] suspend_flags;
    logic engine_busy = 1'b0;
    logic engine_program = 1'b0;
    logic engine_erase = 1'b0;
    logic [31:0] lfsr = 32'hf34b23e8;
    logic [7:0] bad [10] = '{OP_WRITE_STATUS, OP_SEC_ERASE, OP_SECTOR_ERASE, OP_BLOCK32_ERASE,
        OP_BLOCK64_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_SEC_PROGRAM, OP_PAGE_PROGRAM,
        OP_QUAD_PROGRAM};
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    int nvalid = 0;
    int d, w, v;
    fmps_ctrl #(.DEVICE_ID(ID), .RST_NS(5000), .DP_NS(200), .RES1_NS(200), .RES2_NS(200),
        .SUS_NS(200)) fmps_ctrl_inst (.ref_clk, .rst_n, .sclk, .cs_n, .io_in, .io_out, .io_oe,
        .mem_addr, .mem_data, .engine_busy, .engine_program, .engine_erase, .engine_pause,
        .engine_abort, .cmd_valid, .cmd_opcode, .defaults_restore, .write_in_progress,
        .suspend_flags, .quad_command_mode, .deep_power_down, .read_param_bits, .busy);
    fmps_host fmps_host_inst (.sclk, .cs_n, .io_in, .io_out, .io_oe, .mem_addr, .mem_data);
    always #25 ref_clk = ~ref_clk;
    // Forwarded pulses and run limit
    always @(negedge ref_clk)
    begin
        nvalid += int'(cmd_valid === 1'b1);
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            print_verdict();
        end
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] wrap_byte(input logic [7:0] b, input logic [7:0] k,
        input logic [1:0] c);
        logic [7:0] m;
        m = (8'h08 << c) - 8'h01;
        return ((b & ~m) | ((b + k) & m)) ^ 8'ha5;
    endfunction
    function automatic int dummy_bytes(input logic [1:0] c);
        return (c == 2'b11) ? 4 : (c == 2'b10) ? 3 : 2;
    endfunction
    // Status packed as wip, quad, power-down, suspend flags
    function automatic logic [7:0] st();
        return {3'b000, write_in_progress, quad_command_mode, deep_power_down, suspend_flags};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (6) @(negedge ref_clk);
        for (int i = 0; i < 400 && busy !== 1'b0; i++)
            @(negedge ref_clk);
    endtask
    task automatic f(input logic [7:0] op, input logic [7:0] arg, input int nb, input bit q);
        fmps_host_inst.xfer(op, arg, nb, q);
        settle();
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        f(OP_SUSPEND, 8'h00, 0, 1'b0);
        chk(st(), 8'h00);
        f(OP_QUAD_ENABLE, 8'h00, 0, 1'b0);
        chk(st(), 8'h08);
        for (int k = 0; k < 4; k++)
        begin
            lfsr = lfsr_next(lfsr);
            p = {lfsr[7:6], k[1:0], lfsr[3:2], k[1:0]};
            a = lfsr[15:8];
            f(OP_SET_READ_PARAM, p, 1, 1'b1);
            chk(read_param_bits, p);
            d = dummy_bytes(p[5:4]);
            w = 8 << k;
            f(OP_WRAP_READ, a, 4 + d + w, 1'b1);
            chk(fmps_host_inst.rx[5 + d], wrap_byte(a, 8'h01, k[1:0]));
            chk(fmps_host_inst.rx[4 + d + w], wrap_byte(a, 8'(w), k[1:0]));
        end
        {engine_busy, engine_program} = 2'b11;
        repeat (2) @(negedge ref_clk);
        f(OP_SUSPEND, 8'h00, 0, 1'b1);
        repeat (10) @(negedge ref_clk);
        chk(st(), 8'h09);
        v = nvalid;
        foreach (bad[i]) f(bad[i], 8'h00, 0, 1'b1);
        chk(8'(nvalid - v), 8'h00);
        f(OP_QUAD_DISABLE, 8'h00, 0, 1'b1);
        chk(st(), 8'h01);
        chk(read_param_bits, p);
        f(OP_RESUME, 8'h00, 0, 1'b0);
        chk(st(), 8'h10);
        {engine_program, engine_erase} = 2'b01;
        f(OP_SUSPEND, 8'h00, 0, 1'b0);
        repeat (10) @(negedge ref_clk);
        chk(st(), 8'h02);
        v = nvalid;
        foreach (bad[i]) f(bad[i], 8'h00, 0, 1'b0);
        f(8'h0b, 8'h00, 0, 1'b0);
        chk(8'(nvalid - v), 8'h04);
        chk(cmd_opcode, 8'h0b);
        f(OP_RESUME, 8'h00, 0, 1'b0);
        f(OP_POWER_DOWN, 8'h00, 0, 1'b0);
        chk(st(), 8'h10);
        f(OP_RELEASE_ID, 8'h00, 5, 1'b0);
        chk(fmps_host_inst.rx[5], 8'h00);
        {engine_busy, engine_erase} = 2'b00;
        f(OP_POWER_DOWN, 8'h00, 1, 1'b0);
        chk(st(), 8'h00);
        f(OP_POWER_DOWN, 8'h00, 0, 1'b0);
        chk(st(), 8'h04);
        f(OP_QUAD_ENABLE, 8'h00, 0, 1'b0);
        f(OP_SET_READ_PARAM, ~p, 1, 1'b0);
        chk(st(), 8'h04);
        chk(read_param_bits, p);
        f(OP_RELEASE_ID, 8'h00, 0, 1'b0);
        chk(st(), 8'h00);
        f(OP_POWER_DOWN, 8'h00, 0, 1'b0);
        f(OP_RELEASE_ID, 8'h00, 5, 1'b0);
        chk(fmps_host_inst.rx[4], ID);
        chk(fmps_host_inst.rx[5], ID);
        chk(st(), 8'h00);
        {engine_busy, engine_program} = 2'b11;
        repeat (2) @(negedge ref_clk);
        f(OP_SUSPEND, 8'h00, 0, 1'b0);
        f(OP_RESET_ENABLE, 8'h00, 0, 1'b0);
        f(8'h0b, 8'h00, 0, 1'b0);
        f(OP_RESET, 8'h00, 0, 1'b0);
        chk({6'h00, suspend_flags}, 8'h01);
        f(OP_RESET_ENABLE, 8'h00, 0, 1'b0);
        fmps_host_inst.xfer(OP_RESET, 8'h00, 0, 1'b0);
        @(negedge ref_clk) {engine_busy, engine_program} = 2'b00;
        #250 fmps_host_inst.xfer(OP_SET_READ_PARAM, 8'h33, 1, 1'b0);
        settle();
        chk(st(), 8'h00);
        chk(read_param_bits, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
